// file: logic/tcac_params.svh
// constants for the temperature conversion and alert control block
`ifndef TCAC_PARAMS_SVH
`define TCAC_PARAMS_SVH
`define TCAC_CONV_TIME_US    6400
`define TCAC_CONV_CYC        (`TCAC_CONV_TIME_US * 100)
`define TCAC_AVG_SAMPLES     8
`define TCAC_PER0_US         6400
`define TCAC_PER1_US         31250
`define TCAC_PER2_US         125000
`define TCAC_PER3_US         1000000
`define TCAC_CRC_SEED        8'hFF
`define TCAC_CRC_POLY        8'h07
`define TCAC_MODE_CONT       1'b0
`define TCAC_MODE_SHDN       1'b1
`endif

// file: logic/tcac_pkg.sv
// types for the temperature conversion and alert control block
package tcac_pkg;
  typedef enum logic [2:0] {
    TCAC_IDLE = 3'b001,
    TCAC_CONV = 3'b010,
    TCAC_WAIT = 3'b100
  } tcac_state_t;
  typedef enum logic [3:0] {
    TCAC_LK_IDLE = 4'b0001,
    TCAC_LK_DATA = 4'b0010,
    TCAC_LK_CHK  = 4'b0100,
    TCAC_LK_DONE = 4'b1000
  } tcac_link_t;
endpackage

// file: logic/tcac_core.sv
// conversion sequencer, limit and slew alerts, and bus checksum engine
// Behaviour
// RULE1 - checksum off at reset, enabled by config
// RULE2 - accumulator seeded FFh at each start
// RULE3 - accumulator reseeded after each checksum byte
// RULE4 - write checksum covers address, pointer, data
// RULE5 - missing write checksum discards, no flag
// RULE6 - read appends checksum over address and data
// RULE7 - each result compared with both limits
// RULE8 - above upper limit sets status and flag
// RULE9 - status read clears flags, not live bits
// RULE10 - below limit minus hysteresis clears, flags again
// RULE11 - status bits follow every new result
// RULE12 - continuous mode slew rise check sets alert
// RULE13 - slew check suspended outside continuous mode
// RULE14 - continuous mode updates result, sets ready
// RULE15 - conversion 6.4 ms, averaging eight back-to-back
// RULE16 - interval field sets continuous period, standby
// RULE17 - shutdown write aborts, discards partial result
// RULE18 - mode changes keep alerts; no shutdown slew (single-shot trigger clears slew alert)
// RULE19 - single-shot write restarts conversion immediately
// RULE20 - single-shot end clears bit, forces shutdown
// RULE21 - result updates only when conversion completes
// RULE22 - result is 16-bit two's complement
// RULE23 - lower limit mirrors upper with hysteresis
`timescale 1ns/1ps
`include "tcac_params.svh"

module tcac_core #(
  parameter int unsigned CONV_CYC = `TCAC_CONV_CYC,
  parameter int unsigned PER0_CYC = `TCAC_PER0_US * 100,
  parameter int unsigned PER1_CYC = `TCAC_PER1_US * 100,
  parameter int unsigned PER2_CYC = `TCAC_PER2_US * 100,
  parameter int unsigned PER3_CYC = `TCAC_PER3_US * 100
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        mode_shutdown,
  input  wire logic        mode_wr,
  input  wire logic        single_conversion_trigger,
  input  wire logic        averaging_en,
  input  wire logic [1:0]  conv_interval,
  input  wire logic        crc_en,
  input  wire logic [15:0] upper_temp_threshold,
  input  wire logic [15:0] upper_threshold_hysteresis,
  input  wire logic [15:0] lower_temp_threshold,
  input  wire logic [15:0] lower_threshold_hysteresis,
  input  wire logic [15:0] slew_limit,
  input  wire logic        status_read_done,
  input  wire logic [15:0] adc_sample,
  input  wire logic        link_clk,
  input  wire logic        link_start,
  input  wire logic        link_byte_valid,
  input  wire logic [7:0]  link_byte,
  input  wire logic        link_is_crc,
  input  wire logic        link_read,
  input  wire logic        link_stop,
  output logic      [7:0]  link_crc,
  output logic             link_write_ok,
  output logic      [15:0] temp_result,
  output logic             mode_is_shutdown,
  output logic             single_conversion_busy,
  output logic             converting,
  output logic             upper_threshold_active,
  output logic             upper_threshold_event,
  output logic             lower_threshold_active,
  output logic             lower_threshold_event,
  output logic             slew_alert,
  output logic             data_ready,
  output logic             crc_error
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] crc8(input logic [7:0] acc, input logic [7:0] d);
    logic [7:0] c;
    c = acc ^ d;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ `TCAC_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  function automatic logic signed [16:0] sx(input logic [15:0] v);
    return {v[15], v};
  endfunction

  // ----------------------------------------
  // link domain checksum engine
  // ----------------------------------------
  logic [7:0] acc_r;
  logic       wr_good_r;
  logic       wr_bad_r;
  logic       wr_seen_r;
  logic       err_tgl_r;
  logic       crc_en_s1_r;
  logic       crc_en_s2_r;

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      crc_en_s1_r <= 1'b0;
      crc_en_s2_r <= 1'b0;
    end else begin
      crc_en_s1_r <= crc_en;
      crc_en_s2_r <= crc_en_s1_r;
    end
  end

  wire crc_match = (acc_r == link_byte);
  wire byte_data = link_byte_valid && !link_is_crc;
  wire byte_chk  = link_byte_valid && link_is_crc;

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      acc_r     <= `TCAC_CRC_SEED;
      wr_good_r <= 1'b0;
      wr_bad_r  <= 1'b0;
      wr_seen_r <= 1'b0;
      err_tgl_r <= 1'b0;
    end else begin
      if (link_start) begin
        acc_r     <= `TCAC_CRC_SEED; // RULE2
        wr_seen_r <= 1'b0;
        wr_good_r <= 1'b0;
        wr_bad_r  <= 1'b0;
      end else if (byte_chk) begin
        acc_r <= `TCAC_CRC_SEED; // RULE3
        if (!link_read) begin
          wr_seen_r <= 1'b1;
          if (crc_match) begin
            wr_good_r <= 1'b1;
          end else begin
            wr_bad_r <= 1'b1;
          end
        end
      end else if (byte_data) begin
        acc_r <= crc8(acc_r, link_byte); // RULE4 RULE6
      end
      if (link_stop && !link_read && crc_en_s2_r) begin
        if (wr_seen_r && wr_bad_r) begin
          err_tgl_r <= ~err_tgl_r; // RULE4
        end
      end
    end
  end

  // ----------------------------------------
  // link write commit and read checksum
  // ----------------------------------------
  // commit allowed when checksum off, or a good checksum was seen; missing one discards
  assign link_write_ok = !crc_en_s2_r || (wr_seen_r && wr_good_r && !wr_bad_r); // RULE1 RULE5
  assign link_crc      = acc_r; // RULE6

  // ----------------------------------------
  // crossing of checksum error event
  // ----------------------------------------
  logic [2:0] err_sync_r;
  wire        crc_err_evt = err_sync_r[2] ^ err_sync_r[1];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      err_sync_r <= 3'b000;
    end else begin
      err_sync_r <= {err_sync_r[1:0], err_tgl_r};
    end
  end

  // ----------------------------------------
  // conversion sequencer
  // ----------------------------------------
  tcac_pkg::tcac_state_t state_r;
  tcac_pkg::tcac_state_t state_nxt;
  logic [31:0] cnt_r;
  logic [31:0] per_r;
  logic [2:0]  samp_r;
  logic [18:0] sum_r;
  logic        mode_r;
  logic        os_r;
  logic        have_prev_r;
  logic [15:0] prev_r;

  wire [31:0] per_cyc   = (conv_interval == 2'd0) ? PER0_CYC :
                          (conv_interval == 2'd1) ? PER1_CYC :
                          (conv_interval == 2'd2) ? PER2_CYC : PER3_CYC; // RULE16
  wire        conv_end  = (state_r == tcac_pkg::TCAC_CONV) && (cnt_r == CONV_CYC - 1);
  wire        last_samp = !averaging_en || (samp_r == 3'(`TCAC_AVG_SAMPLES - 1)); // RULE15
  wire        result_evt = conv_end && last_samp;
  wire [18:0] sum_fin   = sum_r + {{3{adc_sample[15]}}, adc_sample};
  wire [15:0] new_res   = averaging_en ? sum_fin[18:3] : adc_sample; // RULE22
  wire        stop_req  = mode_wr && mode_shutdown && !single_conversion_trigger; // RULE17
  wire        cont_go   = (mode_r == `TCAC_MODE_CONT) && !os_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      tcac_pkg::TCAC_IDLE: begin
        if (cont_go) begin
          state_nxt = tcac_pkg::TCAC_CONV;
        end
      end
      tcac_pkg::TCAC_CONV: begin
        if (result_evt) begin
          state_nxt = (os_r || mode_r) ? tcac_pkg::TCAC_IDLE : tcac_pkg::TCAC_WAIT;
        end
      end
      tcac_pkg::TCAC_WAIT: begin
        if (mode_r) begin
          state_nxt = tcac_pkg::TCAC_IDLE;
        end else if (per_r >= per_cyc - 1) begin
          state_nxt = tcac_pkg::TCAC_CONV; // RULE16
        end
      end
      default: state_nxt = tcac_pkg::TCAC_IDLE;
    endcase
    if (single_conversion_trigger) begin
      state_nxt = tcac_pkg::TCAC_CONV; // RULE19 RULE21
    end else if (stop_req) begin
      state_nxt = tcac_pkg::TCAC_IDLE; // RULE17
    end
  end

  wire restart = single_conversion_trigger || (state_r != tcac_pkg::TCAC_CONV) ||
                 stop_req;

  // ----------------------------------------
  // sequencer registers
  // ----------------------------------------

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= tcac_pkg::TCAC_IDLE;
      cnt_r   <= 32'd0;
      per_r   <= 32'd0;
      samp_r  <= 3'd0;
      sum_r   <= 19'd0;
      mode_r  <= `TCAC_MODE_CONT;
      os_r    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (restart || conv_end) begin
        cnt_r <= 32'd0; // RULE15
      end else begin
        cnt_r <= cnt_r + 32'd1;
      end
      if (single_conversion_trigger || (state_r == tcac_pkg::TCAC_IDLE) ||
          (state_nxt == tcac_pkg::TCAC_CONV && state_r == tcac_pkg::TCAC_WAIT)) begin
        per_r <= 32'd0;
      end else begin
        per_r <= per_r + 32'd1;
      end
      if (restart || result_evt) begin
        samp_r <= 3'd0; // RULE17 RULE19
        sum_r  <= 19'd0;
      end else if (conv_end) begin
        samp_r <= samp_r + 3'd1; // RULE15
        sum_r  <= sum_fin;
      end
      if (mode_wr) begin
        mode_r <= mode_shutdown;
      end
      if (single_conversion_trigger) begin
        os_r <= 1'b1;
      end else if (result_evt && os_r) begin
        os_r   <= 1'b0; // RULE20
        mode_r <= `TCAC_MODE_SHDN; // RULE20
      end
    end
  end

  // ----------------------------------------
  // result, limits, slew
  // ----------------------------------------
  wire signed [16:0] res_s   = sx(new_res);
  wire signed [16:0] hi_set  = sx(upper_temp_threshold);
  wire signed [16:0] hi_clr  = sx(upper_temp_threshold) - sx(upper_threshold_hysteresis);
  wire signed [16:0] lo_set  = sx(lower_temp_threshold);
  wire signed [16:0] lo_clr  = sx(lower_temp_threshold) + sx(lower_threshold_hysteresis);
  wire               hi_on   = result_evt && !upper_threshold_active && (res_s > hi_set); // RULE7
  wire               hi_off  = result_evt && upper_threshold_active && (res_s < hi_clr);
  wire               lo_on   = result_evt && !lower_threshold_active && (res_s < lo_set);
  wire               lo_off  = result_evt && lower_threshold_active && (res_s > lo_clr);
  wire signed [16:0] rise    = res_s - sx(prev_r);
  wire               slew_on = result_evt && !os_r && (mode_r == `TCAC_MODE_CONT) &&
                               have_prev_r && (rise > $signed({1'b0, slew_limit})); // RULE12

  // ----------------------------------------
  // result and alert registers
  // ----------------------------------------

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      temp_result            <= 16'h0000;
      prev_r                 <= 16'h0000;
      have_prev_r            <= 1'b0;
      upper_threshold_active <= 1'b0;
      upper_threshold_event  <= 1'b0;
      lower_threshold_active <= 1'b0;
      lower_threshold_event  <= 1'b0;
      slew_alert             <= 1'b0;
      data_ready             <= 1'b0;
      crc_error              <= 1'b0;
    end else begin
      if (result_evt) begin
        temp_result <= new_res; // RULE14 RULE21
        prev_r      <= new_res;
      end
      if (result_evt) begin
        have_prev_r <= !os_r && (mode_r == `TCAC_MODE_CONT);
      end else if (mode_r != `TCAC_MODE_CONT) begin
        have_prev_r <= 1'b0; // RULE13
      end
      if (hi_on) begin
        upper_threshold_active <= 1'b1; // RULE8 RULE11
      end else if (hi_off) begin
        upper_threshold_active <= 1'b0; // RULE10
      end
      if (lo_on) begin
        lower_threshold_active <= 1'b1; // RULE23
      end else if (lo_off) begin
        lower_threshold_active <= 1'b0; // RULE23
      end
      // set wins over the clearing read
      upper_threshold_event <= hi_on || hi_off ||
                               (upper_threshold_event && !status_read_done); // RULE8 RULE9
      lower_threshold_event <= lo_on || lo_off ||
                               (lower_threshold_event && !status_read_done); // RULE9
      slew_alert <= slew_on ||
                    (slew_alert && !status_read_done && !single_conversion_trigger); // RULE18
      data_ready <= result_evt || (data_ready && !status_read_done); // RULE14
      crc_error  <= crc_err_evt || (crc_error && !status_read_done); // RULE4
    end
  end

  // ----------------------------------------
  // status outputs
  // ----------------------------------------
  assign mode_is_shutdown       = mode_r;
  assign single_conversion_busy = os_r;
  assign converting             = (state_r == tcac_pkg::TCAC_CONV);

endmodule

// file: tb/tcac_core_monitor.sv
// assertion checker for the conversion and alert block
`timescale 1ns/1ps
module tcac_core_monitor (
  input logic        mclk,
  input logic        rst,
  input logic        mode_shutdown,
  input logic        mode_wr,
  input logic        single_conversion_trigger,
  input logic        crc_en,
  input logic        status_read_done,
  input logic [15:0] temp_result,
  input logic        converting,
  input logic        mode_is_shutdown,
  input logic        single_conversion_busy,
  input logic        upper_threshold_active,
  input logic        upper_threshold_event,
  input logic        lower_threshold_active,
  input logic        lower_threshold_event,
  input logic        slew_alert,
  input logic        data_ready,
  input logic        crc_error
);
  // ----------
  // properties
  // ----------
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_trig_conv: assert property (single_conversion_trigger |=> converting)
    else $error("no conversion after trigger");
  a_shdn_abort: assert property (mode_wr && mode_shutdown && !single_conversion_trigger
    |=> !converting ##1 !converting) else $error("shutdown did not abort");
  a_flag_sticky: assert property ($fell(upper_threshold_event) |-> $past(status_read_done))
    else $error("flag cleared without read");
  a_upper_set: assert property ($rose(upper_threshold_active) |-> upper_threshold_event)
    else $error("upper set without flag");
  a_upper_clr: assert property ($fell(upper_threshold_active) |-> upper_threshold_event)
    else $error("upper clear without flag");
  a_lower_set: assert property ($rose(lower_threshold_active) |-> lower_threshold_event)
    else $error("lower set without flag");
  a_ready_result: assert property ($changed(temp_result) |-> data_ready)
    else $error("result without ready");
  a_shot_end: assert property ($fell(single_conversion_busy) |-> mode_is_shutdown)
    else $error("single shot end not shutdown");
  a_slew_cont: assert property ($rose(slew_alert) |-> !mode_is_shutdown)
    else $error("slew alert in shutdown");
  a_crc_off: assert property ($rose(crc_error) |-> $past(crc_en, 4))
    else $error("checksum error while disabled");
  c_upper: cover property ($rose(upper_threshold_active));
  c_slew: cover property ($rose(slew_alert));
  c_shot: cover property ($fell(single_conversion_busy));
endmodule

bind tcac_core tcac_core_monitor tcac_core_monitor_i (.mclk, .rst, .mode_shutdown, .mode_wr,
  .single_conversion_trigger, .crc_en, .status_read_done, .temp_result, .converting,
  .mode_is_shutdown, .single_conversion_busy, .upper_threshold_active, .upper_threshold_event,
  .lower_threshold_active, .lower_threshold_event, .slew_alert, .data_ready, .crc_error);

// file: tb/tcac_ctrl_model.sv
// controller model sending checksummed write transfers on the link
`timescale 1ns/1ps
module tcac_ctrl_model (
  input  logic       link_clk,
  input  logic       rst,
  input  logic       go,
  input  logic       send_crc,
  input  logic       corrupt,
  input  logic       rd,
  input  logic [7:0] link_crc,
  input  logic       link_write_ok,
  output logic       link_start,
  output logic       link_byte_valid,
  output logic [7:0] link_byte,
  output logic       link_is_crc,
  output logic       link_read,
  output logic       link_stop,
  output logic       done,
  output logic       wr_ok,
  output logic [7:0] crc_seen,
  output logic [7:0] crc_exp,
  output logic [7:0] crc_end
);
  logic [7:0] msg [3] = '{8'h92, 8'h01, 8'h5A};
  logic [2:0] st;
  logic       g1, g2;
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
    return r;
  endfunction
  assign link_read = rd;
  always @(posedge link_clk or posedge rst) begin
    if (rst) begin
      {st, g1, g2, done, wr_ok} <= '0;
      {link_start, link_byte_valid, link_is_crc, link_stop} <= '0;
      {link_byte, crc_seen, crc_end} <= '0;
      crc_exp <= 8'hFF;
    end else begin
      g1 <= go;
      g2 <= g1;
      {link_start, link_byte_valid, link_is_crc, link_stop} <= '0;
      link_byte <= ~link_byte;
      if (!g2) done <= 1'b0;
      case (st)
        3'd0: if (g2 && !done) begin
          link_start <= 1'b1;
          crc_exp <= 8'hFF;
          st <= 3'd1;
        end
        3'd1, 3'd2, 3'd3: begin
          link_byte_valid <= 1'b1;
          link_byte <= msg[st - 3'd1];
          crc_exp <= crc8(crc_exp, msg[st - 3'd1]);
          st <= st + 3'd1;
        end
        3'd4: begin
          link_byte_valid <= send_crc;
          link_is_crc <= send_crc;
          if (send_crc) link_byte <= crc_exp ^ {7'h00, corrupt};
          st <= 3'd5;
        end
        3'd5: begin
          link_stop <= 1'b1;
          crc_seen <= link_crc;
          st <= 3'd6;
        end
        default: begin
          wr_ok <= link_write_ok;
          crc_end <= link_crc;
          done <= 1'b1;
          st <= 3'd0;
        end
      endcase
    end
  end
endmodule

// file: tb/tcac_core_test.sv
// self-checking bench for the conversion, alert and checksum block
`timescale 1ns/1ps
module tcac_core_test;
  logic mclk = 1'b0, link_clk = 1'b0, rst = 1'b1, mode_shutdown = 1'b0, mode_wr = 1'b0;
  logic single_conversion_trigger = 1'b0, averaging_en = 1'b0, crc_en = 1'b0;
  logic status_read_done = 1'b0, go = 1'b0, send_crc = 1'b0, corrupt = 1'b0, rd = 1'b0;
  logic [1:0]  conv_interval = 2'h0;
  logic [15:0] upper_temp_threshold = 16'h0100, upper_threshold_hysteresis = 16'h0020;
  logic [15:0] lower_temp_threshold = 16'hFF00, lower_threshold_hysteresis = 16'h0020;
  logic [15:0] slew_limit = 16'h7FFF, adc_sample = 16'h0000, temp_result;
  logic link_start, link_byte_valid, link_is_crc, link_read, link_stop, link_write_ok;
  logic [7:0]  link_byte, link_crc, crc_seen, crc_exp, crc_end;
  logic done, wr_ok, mode_is_shutdown, single_conversion_busy, converting, data_ready;
  logic upper_threshold_active, upper_threshold_event, lower_threshold_active;
  logic lower_threshold_event, slew_alert, crc_error;
  int   failures = 0, n_checks = 0, waited;

  always #5 mclk = ~mclk;
  always #16 link_clk = ~link_clk;

  tcac_core #(.CONV_CYC(50), .PER0_CYC(200), .PER1_CYC(300), .PER2_CYC(400), .PER3_CYC(500))
    tcac_core_i (.mclk, .rst, .mode_shutdown, .mode_wr, .single_conversion_trigger,
    .averaging_en, .conv_interval, .crc_en, .upper_temp_threshold, .upper_threshold_hysteresis,
    .lower_temp_threshold, .lower_threshold_hysteresis, .slew_limit, .status_read_done,
    .adc_sample, .link_clk, .link_start, .link_byte_valid, .link_byte, .link_is_crc, .link_read,
    .link_stop, .link_crc, .link_write_ok, .temp_result, .mode_is_shutdown,
    .single_conversion_busy, .converting, .upper_threshold_active, .upper_threshold_event,
    .lower_threshold_active, .lower_threshold_event, .slew_alert, .data_ready, .crc_error);
  tcac_ctrl_model tcac_ctrl_model_i (.link_clk, .rst, .go, .rd, .send_crc, .corrupt, .link_crc,
    .link_write_ok, .link_start, .link_byte_valid, .link_byte, .link_is_crc, .link_read,
    .link_stop, .done, .wr_ok, .crc_seen, .crc_exp, .crc_end);

  // -----
  // tasks
  // -----
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task pulse_read;
    @(posedge mclk) status_read_done <= 1'b1;
    @(posedge mclk) status_read_done <= 1'b0;
    #1;
  endtask
  task trig;
    @(posedge mclk) single_conversion_trigger <= 1'b1;
    @(posedge mclk) single_conversion_trigger <= 1'b0;
    #1;
  endtask
  task wait_ready;
    waited = 0;
    while (data_ready !== 1'b1 && waited < 3000) begin
      @(posedge mclk);
      #1 waited++;
    end
    chk({15'h0, data_ready}, 16'h0001);
  endtask
  task conv(input logic [15:0] s);
    @(posedge mclk) adc_sample <= s;
    pulse_read;
    wait_ready;
  endtask
  task txn(input logic c, input logic k);
    @(posedge mclk) send_crc <= c;
    corrupt <= k;
    go <= 1'b1;
    waited = 0;
    while (done !== 1'b1 && waited++ < 500) @(posedge mclk);
    go <= 1'b0;
    while (done !== 1'b0 && waited++ < 900) @(posedge mclk);
    repeat (20) @(posedge mclk);
    #1 chk({15'h0, waited < 900}, 16'h0001);
  endtask

  initial begin
    #400_000 failures++;
    close_out;
  end

  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk({15'h0, crc_error}, 16'h0000);
    conv(16'h0200);
    chk(temp_result, 16'h0200);
    chk({upper_threshold_active, upper_threshold_event}, 16'h0003);
    pulse_read;
    chk({upper_threshold_active, upper_threshold_event}, 16'h0002);
    conv(16'h00F0);
    chk({upper_threshold_active, upper_threshold_event}, 16'h0002);
    conv(16'h00D0);
    chk({upper_threshold_active, upper_threshold_event}, 16'h0001);
    conv(16'hFE00);
    chk({lower_threshold_active, lower_threshold_event}, 16'h0003);
    @(posedge mclk) slew_limit <= 16'h0100;
    conv(16'h0000);
    conv(16'h0080);
    chk({15'h0, slew_alert}, 16'h0000);
    conv(16'h0200);
    chk({15'h0, slew_alert}, 16'h0001);
    @(posedge mclk) conv_interval <= 2'h1;
    conv(16'h0200);
    conv(16'h0200);
    chk({15'h0, waited >= 290 && waited <= 300}, 16'h0001);
    @(posedge mclk) averaging_en <= 1'b1;
    conv_interval <= 2'h3;
    conv(16'h0333);
    chk(temp_result, 16'h0333);
    pulse_read;
    while (converting !== 1'b1) @(posedge mclk);
    repeat (220) @(posedge mclk);
    adc_sample <= 16'h0733;
    wait_ready;
    chk(temp_result, 16'h0533);
    @(posedge mclk) averaging_en <= 1'b0;
    pulse_read;
    while (converting !== 1'b1) @(posedge mclk);
    mode_wr <= 1'b1;
    mode_shutdown <= 1'b1;
    adc_sample <= 16'h0777;
    @(posedge mclk) mode_wr <= 1'b0;
    #1 chk({converting, mode_is_shutdown}, 16'h0001);
    repeat (600) @(posedge mclk);
    #1 chk({data_ready, slew_alert}, 16'h0000);
    chk(temp_result, 16'h0533);
    @(posedge mclk) mode_wr <= 1'b1;
    mode_shutdown <= 1'b0;
    @(posedge mclk) mode_wr <= 1'b0;
    repeat (5) @(posedge mclk);
    trig;
    repeat (20) @(posedge mclk) adc_sample <= 16'h1234;
    pulse_read;
    trig;
    wait_ready;
    chk({15'h0, waited >= 45 && waited <= 55}, 16'h0001);
    chk(temp_result, 16'h1234);
    chk({mode_is_shutdown, single_conversion_busy}, 16'h0002);
    txn(1'b1, 1'b1);
    chk({15'h0, crc_error}, 16'h0000);
    @(posedge mclk) crc_en <= 1'b1;
    txn(1'b1, 1'b0);
    chk({wr_ok, crc_error}, 16'h0002);
    chk({8'h00, crc_seen}, {8'h00, crc_exp});
    chk({8'h00, crc_end}, 16'h00FF);
    txn(1'b1, 1'b1);
    chk({15'h0, crc_error}, 16'h0001);
    pulse_read;
    txn(1'b0, 1'b0);
    chk({wr_ok, crc_error}, 16'h0000);
    @(posedge mclk) rd <= 1'b1;
    txn(1'b1, 1'b1);
    chk({8'h00, crc_seen}, {8'h00, crc_exp});
    chk({crc_end, 7'h00, crc_error}, 16'hFF00);
    close_out;
  end
endmodule
